/* File: hdl/pb_err_pkg.sv */
// constants and carrier types for the processor bus error log and misc control block
// assumes a single processor bus clock and a synchronous active-low reset
package pb_err_pkg;

  // register offsets on the 12-bit register port
  localparam logic [11:0] ERR_CTRL_STATUS_OFS = 12'h02b0;
  localparam logic [11:0] ERR_ADDR_LOG_OFS    = 12'h02b4;
  localparam logic [11:0] MISC_CTRL_OFS       = 12'h02c0;

  // error control/status field positions
  localparam int MULTI_ERR_BIT = 25;
  localparam int ERR_FLAG_BIT  = 24;
  localparam int TT_LOG_LSB    = 11;
  localparam int SIZ_LOG_LSB   = 4;

  // misc control field positions
  localparam int RETRY_LIM_LSB = 8;
  localparam int EXT_CYCLE_BIT = 7;
  localparam int CFG_ONES_BIT  = 6;
  localparam int MISALIGN_BIT  = 5;
  localparam int XFER_ERR_BIT  = 4;
  localparam int ADDR_RTY_BIT  = 3;
  localparam int DPAR_EN_BIT   = 2;
  localparam int APAR_EN_BIT   = 1;
  localparam int PAR_SEL_BIT   = 0;

  // retries per step of the retry limit field
  localparam int RETRY_UNIT = 64;

  // misc control word, layout matches bits 11:0 of the register
  typedef struct packed {
    logic [3:0] retry_limit;
    logic       extended_cycle_enable;
    logic       cfg_abort_all_ones_select;
    logic       misaligned_mode;
    logic       transfer_error_signal_enable;
    logic       address_retry_enable;
    logic       data_parity_check_enable;
    logic       address_parity_check_enable;
    logic       parity_even;
  } misc_ctrl_t;

  localparam misc_ctrl_t MISC_CTRL_RESET = 12'h0070;

  // logged error record
  typedef struct packed {
    logic [31:0] addr;
    logic [4:0]  tt;
    logic [3:0]  siz;
  } err_rec_t;

  localparam err_rec_t ERR_REC_RESET = '0;

endpackage

/* File: hdl/pb_lane_parity.sv */
// per-byte-lane parity generator and checker
// assumes bus sampled synchronously to clk; check result is one registered pulse
`timescale 1ns/1ps
`default_nettype none
module pb_lane_parity #(
  parameter int LANES = 4
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [LANES*8-1:0] bus_val,
  input  wire logic [LANES-1:0]   par_in,
  input  wire logic               sample,
  input  wire logic               check_en,
  input  wire logic               even_sel,
  output logic      [LANES-1:0]   par_gen,
  output logic                    par_err
);

  logic [LANES-1:0] mism;

  // parity per lane; odd sense adds the inverting term
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign par_gen[i] = (^bus_val[i*8 +: 8]) ^ ~even_sel;
    assign mism[i]    = par_gen[i] ^ par_in[i];
  end

  // mismatch only counted while checking is enabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      par_err <= 1'b0;
    end else begin
      par_err <= sample && check_en && (|mism);
    end
  end

endmodule
`default_nettype wire

/* File: hdl/proc_bus_error_log_and_misc_ctrl.sv */
// processor bus error address log and miscellaneous control/status registers
// assumes one processor bus clock, register port requests synchronous to clk
// Operation
// - address of a failing transaction is stored in the address log
// - max retry error, parity error or own transfer error ack trigger logging
// - logging sets the error flag, which freezes the log contents
// - later errors do not overwrite the log while the flag is set, except in the cycle of a clearing write
// - software writes one to the flag to clear it and re-arm logging
// - second error while logged sets multiple-error flag; cleared with error flag
// - retry limit zero means unlimited, otherwise N times 64 retries
// - extended 16 or 24 byte master cycles only when enabled
// - config master-abort returns all ones or transfer error as selected
// - misaligned transfer set accepted only when mode bit set; resets set
// - transfer error ack never driven when its signalling is disabled
// - address retry driven only when enabled, always when condition applies
// - retry register writes during other writer, reads during eeprom load
// - retry posted writes with no free buffer and all reads toward pci
// - prefetched data kept only while address retry is enabled
// - data parity checked only when enabled; mismatch is parity error
// - address parity checked only when enabled; mismatch is parity error
`timescale 1ns/1ps
`default_nettype none
module proc_bus_error_log_and_misc_ctrl
  import pb_err_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic        reg_req,
  input  wire logic        reg_wr,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  // slave transaction in flight
  input  wire logic        slv_valid,
  input  wire logic [31:0] slv_addr,
  input  wire logic [4:0]  slv_tt,
  input  wire logic [3:0]  slv_siz,
  input  wire logic        slv_reg_write,
  input  wire logic        slv_reg_read,
  input  wire logic        slv_posted_write,
  input  wire logic        slv_pci_read,
  input  wire logic        slv_misaligned,
  input  wire logic        other_reg_write_busy,
  input  wire logic        eeprom_loading,
  input  wire logic        write_buffer_free,
  input  wire logic        slv_fault,
  input  wire logic        cfg_master_abort,
  input  wire logic        prefetch_keep_enable,
  // own master transaction
  input  wire logic        mst_retried,
  input  wire logic        mst_done,
  input  wire logic [31:0] mst_addr,
  input  wire logic [4:0]  mst_tt,
  input  wire logic [3:0]  mst_siz,
  input  wire logic        mst_ext_req,
  // parity pins
  input  wire logic [31:0] addr_bus,
  input  wire logic [3:0]  addr_par_in,
  input  wire logic [63:0] data_bus,
  input  wire logic [7:0]  data_par_in,
  input  wire logic        addr_sample,
  input  wire logic        data_sample,
  output logic      [3:0]  addr_par_out,
  output logic      [7:0]  data_par_out,
  // processor bus control outputs (open drain, low active), then active-high internal controls
  output logic             bus_transfer_error_ack_n_o,
  output logic             bus_transfer_error_ack_n_oe,
  output logic             bus_address_retry_n_o,
  output logic             bus_address_retry_n_oe,
  output logic             cfg_all_ones,
  output logic             mst_abandon,
  output logic             mst_ext_allow,
  output logic             misaligned_accept,
  output logic             prefetch_keep_active,
  output misc_ctrl_t       misc_ctrl
);

  misc_ctrl_t       misc_r;
  err_rec_t         log_r;
  logic             err_flag_r;
  logic             multi_err_r;
  logic             tea_r;
  logic             artry_r;
  logic             ones_r;
  logic             abandon_r;
  logic [CNT_W-1:0] retry_cnt_r;
  logic [CNT_W-1:0] retry_cnt_nxt;
  logic [CNT_W-1:0] retry_lim;
  logic             addr_perr;
  logic             data_perr;
  logic             err_evt;
  logic             err_clr;
  logic             wr_misc;
  logic             retry_cond;
  logic             tea_cause;
  err_rec_t         err_src;

  assign misc_ctrl = misc_r;

  // software write strobes
  assign wr_misc = reg_req && reg_wr && (reg_addr == MISC_CTRL_OFS);
  assign err_clr = reg_req && reg_wr && (reg_addr == ERR_CTRL_STATUS_OFS)
                   && reg_wdata[ERR_FLAG_BIT];

  // misc control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      misc_r <= MISC_CTRL_RESET;
    end else if (wr_misc) begin
      misc_r <= reg_wdata[RETRY_LIM_LSB+3:0];
    end
  end

  // register read data and one-cycle acknowledge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack   <= reg_req;
      reg_rdata <= 32'h0000_0000;
      if (reg_req && !reg_wr) begin
        case (reg_addr)
          ERR_CTRL_STATUS_OFS: begin
            reg_rdata[MULTI_ERR_BIT]              <= multi_err_r;
            reg_rdata[ERR_FLAG_BIT]               <= err_flag_r;
            reg_rdata[TT_LOG_LSB +: 5]            <= log_r.tt;
            reg_rdata[SIZ_LOG_LSB +: 4]           <= log_r.siz;
          end
          ERR_ADDR_LOG_OFS: reg_rdata <= log_r.addr;
          MISC_CTRL_OFS:    reg_rdata[RETRY_LIM_LSB+3:0] <= misc_r;
          default:          reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // parity generation and checking, address lanes
  pb_lane_parity #(
    .LANES(4)
  ) u_addr_par (
    .clk      (clk),
    .rst_n    (rst_n),
    .bus_val  (addr_bus),
    .par_in   (addr_par_in),
    .sample   (addr_sample),
    .check_en (misc_r.address_parity_check_enable),
    .even_sel (misc_r.parity_even),
    .par_gen  (addr_par_out),
    .par_err  (addr_perr)
  );

  // parity generation and checking, data lanes
  pb_lane_parity #(
    .LANES(8)
  ) u_data_par (
    .clk      (clk),
    .rst_n    (rst_n),
    .bus_val  (data_bus),
    .par_in   (data_par_in),
    .sample   (data_sample),
    .check_en (misc_r.data_parity_check_enable),
    .even_sel (misc_r.parity_even),
    .par_gen  (data_par_out),
    .par_err  (data_perr)
  );

  // retry limit in retries; zero means no limit
  assign retry_lim = CNT_W'(misc_r.retry_limit) * CNT_W'(RETRY_UNIT);

  // retry counter next value
  always_comb begin
    retry_cnt_nxt = retry_cnt_r;
    if (mst_done || abandon_r) begin
      retry_cnt_nxt = '0;
    end else if (mst_retried) begin
      retry_cnt_nxt = retry_cnt_r + CNT_W'(1);
    end
  end

  // master retry counting and abandon pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      retry_cnt_r <= '0;
      abandon_r   <= 1'b0;
    end else begin
      retry_cnt_r <= retry_cnt_nxt;
      abandon_r   <= !abandon_r && !mst_done && mst_retried
                     && (misc_r.retry_limit != 4'h0)
                     && (retry_cnt_nxt == retry_lim);
    end
  end

  assign mst_abandon   = abandon_r;
  assign mst_ext_allow = mst_ext_req && misc_r.extended_cycle_enable;

  // slave accepts misaligned set only in that mode
  assign misaligned_accept = slv_valid && slv_misaligned && misc_r.misaligned_mode;

  // prefetch data kept only with address retry on
  assign prefetch_keep_active = prefetch_keep_enable && misc_r.address_retry_enable;

  // slave retry conditions
  assign retry_cond = slv_valid && (
      (slv_reg_write && other_reg_write_busy) ||
      (slv_reg_read && eeprom_loading) ||
      (slv_posted_write && !write_buffer_free) ||
      slv_pci_read);

  // address retry driven only when enabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      artry_r <= 1'b0;
    end else begin
      artry_r <= retry_cond && misc_r.address_retry_enable;
    end
  end

  assign bus_address_retry_n_o  = 1'b0;
  assign bus_address_retry_n_oe = artry_r;

  // transfer error causes: slave fault or mapped config abort
  assign tea_cause = slv_fault
                     || (cfg_master_abort && !misc_r.cfg_abort_all_ones_select);

  // transfer error ack and all-ones answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tea_r  <= 1'b0;
      ones_r <= 1'b0;
    end else begin
      tea_r  <= tea_cause && misc_r.transfer_error_signal_enable;
      ones_r <= cfg_master_abort && misc_r.cfg_abort_all_ones_select;
    end
  end

  assign bus_transfer_error_ack_n_o  = 1'b0;
  assign bus_transfer_error_ack_n_oe = tea_r;
  assign cfg_all_ones                = ones_r;

  // logging events; master address used for max retry errors
  assign err_evt = abandon_r || addr_perr || data_perr || tea_r;
  assign err_src = abandon_r ? err_rec_t'{addr: mst_addr, tt: mst_tt, siz: mst_siz}
                             : err_rec_t'{addr: slv_addr, tt: slv_tt, siz: slv_siz};

  // error flag; a new error wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_flag_r <= 1'b0;
    end else if (err_evt) begin
      err_flag_r <= 1'b1;
    end else if (err_clr) begin
      err_flag_r <= 1'b0;
    end
  end

  // log capture only while disarmed flag or being cleared
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      log_r <= ERR_REC_RESET;
    end else if (err_evt && (!err_flag_r || err_clr)) begin
      log_r <= err_src;
    end
  end

  // multiple error flag follows the error flag clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      multi_err_r <= 1'b0;
    end else if (err_clr) begin
      multi_err_r <= 1'b0;
    end else if (err_evt && err_flag_r) begin
      multi_err_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_log_frozen;
    err_flag_r && !err_clr |=> $stable(log_r);
  endproperty
  a_log_frozen: assert property (p_log_frozen) else $error("log changed while frozen");

  property p_log_capture;
    err_evt && !err_flag_r |=> err_flag_r && (log_r.addr == $past(err_src.addr));
  endproperty
  a_log_capture: assert property (p_log_capture) else $error("error not logged");

  property p_flag_set;
    err_evt |=> err_flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("error flag not set");

  property p_clear;
    err_clr && !err_evt |=> !err_flag_r && !multi_err_r;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");

  property p_multi;
    err_evt && err_flag_r && !err_clr |=> multi_err_r;
  endproperty
  a_multi: assert property (p_multi) else $error("multiple error not flagged");

  property p_no_limit;
    misc_r.retry_limit == 4'h0 |=> !abandon_r;
  endproperty
  a_no_limit: assert property (p_no_limit) else $error("abandon with no limit");

  property p_abandon;
    abandon_r |-> $past(retry_cnt_r) + CNT_W'(1) == $past(retry_lim);
  endproperty
  a_abandon: assert property (p_abandon) else $error("abandon off limit");

  property p_tea_off;
    !misc_r.transfer_error_signal_enable ##1 !$past(wr_misc) |-> !bus_transfer_error_ack_n_oe;
  endproperty
  a_tea_off: assert property (p_tea_off) else $error("transfer error while disabled");

  property p_artry;
    retry_cond && misc_r.address_retry_enable |=> bus_address_retry_n_oe;
  endproperty
  a_artry: assert property (p_artry) else $error("retry not driven");

  property p_artry_off;
    bus_address_retry_n_oe |-> $past(misc_r.address_retry_enable);
  endproperty
  a_artry_off: assert property (p_artry_off) else $error("retry while disabled");

  property p_ones;
    cfg_master_abort && misc_r.cfg_abort_all_ones_select
      |=> cfg_all_ones && (!tea_r || $past(slv_fault));
  endproperty
  a_ones: assert property (p_ones) else $error("config abort mapping wrong");

endmodule
`default_nettype wire

/* File: test/pb_master_model.sv */
// far-side bus master that is retried a set number of times
// assumes go is a one-cycle pulse synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module pb_master_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic [11:0] n_retry,
  input  wire logic [31:0] go_addr,
  input  wire logic        mst_abandon,
  output logic             mst_retried,
  output logic             mst_done,
  output logic      [31:0] mst_addr,
  output logic      [4:0]  mst_tt,
  output logic      [3:0]  mst_siz
);
  logic        busy_r;
  logic [11:0] left_r;

  // one retry a cycle, then done unless the bridge gives up first
  always_ff @(posedge clk) begin
    mst_retried <= 1'b0;
    mst_done    <= 1'b0;
    if (!rst_n) begin
      busy_r   <= 1'b0;
      mst_addr <= '0;
    end else if (go) begin
      busy_r   <= 1'b1;
      left_r   <= n_retry;
      mst_addr <= go_addr;
    end else if (busy_r && mst_abandon) begin
      busy_r   <= 1'b0;
      mst_addr <= ~mst_addr; // released: inverse shown
    end else if (busy_r && left_r != 12'h000) begin
      mst_retried <= 1'b1;
      left_r      <= left_r - 12'h001;
    end else if (busy_r && !mst_retried) begin
      mst_done <= 1'b1;
      busy_r   <= 1'b0;
      mst_addr <= ~mst_addr;
    end
  end

  // fixed attributes of the retried transfer
  assign mst_tt  = 5'h0a;
  assign mst_siz = 4'h4;
endmodule
`default_nettype wire

/* File: test/tb_proc_bus_error_log_and_misc_ctrl.sv */
// bench for the bus error log and misc control registers
// assumes the far-side master model and a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_proc_bus_error_log_and_misc_ctrl;
  import pb_err_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, reg_req = 1'b0, reg_wr = 1'b0, go = 1'b0;
  logic [11:0] reg_addr = '0, n_retry = '0;
  logic [31:0] reg_wdata = '0, go_addr = '0, slv_addr = '0, reg_rdata, mst_addr;
  logic        slv_valid = 1'b0, slv_reg_write = 1'b0, slv_reg_read = 1'b0;
  logic        slv_posted_write = 1'b0, slv_pci_read = 1'b0, slv_misaligned = 1'b0;
  logic        other_reg_write_busy = 1'b0, eeprom_loading = 1'b0;
  logic        write_buffer_free = 1'b1, slv_fault = 1'b0, cfg_master_abort = 1'b0;
  logic        prefetch_keep_enable = 1'b0, mst_ext_req = 1'b0;
  logic        addr_sample = 1'b0, data_sample = 1'b0;
  logic [4:0]  slv_tt = 5'h0c, mst_tt;
  logic [3:0]  slv_siz = 4'h8, mst_siz, addr_par_in = 4'h2, addr_par_out;
  logic [31:0] addr_bus = 32'h0102_0307;
  logic [63:0] data_bus = 64'h0000_0000_0102_0307;
  logic [7:0]  data_par_in = 8'hf2, data_par_out;
  logic        reg_ack, mst_retried, mst_done, mst_abandon, mst_ext_allow;
  logic        cfg_all_ones, misaligned_accept, prefetch_keep_active;
  logic        bus_transfer_error_ack_n_o, bus_transfer_error_ack_n_oe;
  logic        bus_address_retry_n_o, bus_address_retry_n_oe;
  misc_ctrl_t  misc_ctrl;
  int          num_errors = 0, comparisons = 0;

  proc_bus_error_log_and_misc_ctrl #(.CNT_W(10)) dut (
    .clk, .rst_n, .reg_req, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack,
    .slv_valid, .slv_addr, .slv_tt, .slv_siz, .slv_reg_write, .slv_reg_read,
    .slv_posted_write, .slv_pci_read, .slv_misaligned, .other_reg_write_busy,
    .eeprom_loading, .write_buffer_free, .slv_fault, .cfg_master_abort,
    .prefetch_keep_enable, .mst_retried, .mst_done, .mst_addr, .mst_tt, .mst_siz,
    .mst_ext_req, .addr_bus, .addr_par_in, .data_bus, .data_par_in, .addr_sample,
    .data_sample, .addr_par_out, .data_par_out, .bus_transfer_error_ack_n_o,
    .bus_transfer_error_ack_n_oe, .bus_address_retry_n_o, .bus_address_retry_n_oe,
    .cfg_all_ones, .mst_abandon, .mst_ext_allow, .misaligned_accept,
    .prefetch_keep_active, .misc_ctrl);
  pb_master_model far (
    .clk, .rst_n, .go, .n_retry, .go_addr, .mst_abandon, .mst_retried, .mst_done,
    .mst_addr, .mst_tt, .mst_siz);

  // clock
  initial begin
    forever #5 clk = ~clk;
  end

  // helpers: step, compare, register access
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic reg_rw(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    reg_req = 1'b1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = d;
    tick;
    reg_req = 1'b0;
    q = reg_rdata;
    chk({31'h0, reg_ack}, 32'h1);
    tick;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    reg_rw(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    reg_rw(1'b0, a, '0, q);
    chk(q, e);
  endtask
  task automatic flags(input logic [1:0] e);
    logic [31:0] q;
    reg_rw(1'b0, ERR_CTRL_STATUS_OFS, '0, q);
    chk({30'h0, q[MULTI_ERR_BIT:ERR_FLAG_BIT]}, {30'h0, e});
  endtask
  task automatic clr;
    wr(ERR_CTRL_STATUS_OFS, 32'h0100_0000);
  endtask

  // stimulus pieces: slave fault, config abort, master run, parity, retry
  task automatic fault(input logic [31:0] a, input logic e);
    slv_valid = 1'b1;
    slv_addr = a;
    slv_fault = 1'b1;
    tick;
    slv_fault = 1'b0;
    chk({30'h0, bus_transfer_error_ack_n_o, bus_transfer_error_ack_n_oe}, {31'h0, e});
    tick;
    slv_valid = 1'b0;
    tick;
  endtask
  task automatic abort(input logic [1:0] e);
    cfg_master_abort = 1'b1;
    tick;
    cfg_master_abort = 1'b0;
    chk({30'h0, cfg_all_ones, bus_transfer_error_ack_n_oe}, {30'h0, e});
    tick;
  endtask
  task automatic run_mst(input logic [11:0] n, input logic [31:0] a, input logic e);
    n_retry = n;
    go_addr = a;
    go = 1'b1;
    tick;
    go = 1'b0;
    repeat (500) if (!(mst_done || mst_abandon)) tick;
    chk({31'h0, mst_abandon}, {31'h0, e});
    tick;
  endtask
  task automatic psample(input logic [1:0] s, input logic [1:0] e);
    {data_sample, addr_sample} = s;
    tick;
    {data_sample, addr_sample} = 2'b00;
    tick;
    tick;
    flags(e);
  endtask
  task automatic retry_chk(input logic [3:0] c, input logic e);
    slv_valid = 1'b1;
    {slv_reg_write, other_reg_write_busy} = {2{c[0]}};
    {slv_reg_read, eeprom_loading} = {2{c[1]}};
    {slv_posted_write, write_buffer_free} = {c[2], !c[2]};
    slv_pci_read = c[3];
    tick;
    chk({30'h0, bus_address_retry_n_o, bus_address_retry_n_oe}, {31'h0, e});
    {slv_valid, slv_reg_write, slv_reg_read, slv_posted_write, slv_pci_read} = '0;
    {other_reg_write_busy, eeprom_loading, write_buffer_free} = 3'b001;
    tick;
  endtask

  // scenarios
  task automatic t_reset;
    rd(MISC_CTRL_OFS, 32'h0000_0070);
    rd(ERR_ADDR_LOG_OFS, '0);
    flags(2'b00);
    rd(12'h0100, '0);
    wr(ERR_ADDR_LOG_OFS, 32'hffff_ffff);
    rd(ERR_ADDR_LOG_OFS, '0);
    wr(MISC_CTRL_OFS, 32'hffff_ffff);
    rd(MISC_CTRL_OFS, 32'h0000_0fff);
  endtask
  task automatic t_log;
    wr(MISC_CTRL_OFS, 32'h0000_0070);
    fault(32'h1234_5678, 1'b1);
    rd(ERR_ADDR_LOG_OFS, 32'h1234_5678);
    flags(2'b01);
    rd(ERR_CTRL_STATUS_OFS, 32'h0100_6080);
    fault(32'h9abc_def0, 1'b1);
    rd(ERR_ADDR_LOG_OFS, 32'h1234_5678);
    flags(2'b11);
    clr;
    flags(2'b00);
    fault(32'h0bad_cafe, 1'b1);
    rd(ERR_ADDR_LOG_OFS, 32'h0bad_cafe);
    clr;
    wr(MISC_CTRL_OFS, 32'h0000_0020);
    fault(32'h5555_aaaa, 1'b0);
    flags(2'b00);
    abort(2'b00);
    wr(MISC_CTRL_OFS, 32'h0000_0070);
    abort(2'b10);
    wr(MISC_CTRL_OFS, 32'h0000_0030);
    abort(2'b01);
    clr;
  endtask
  task automatic t_limit;
    wr(MISC_CTRL_OFS, 32'h0000_0170);
    run_mst(12'h03f, 32'h0000_1000, 1'b0);
    run_mst(12'h040, 32'h0000_2000, 1'b1);
    rd(ERR_ADDR_LOG_OFS, 32'h0000_2000);
    flags(2'b01);
    rd(ERR_CTRL_STATUS_OFS, 32'h0100_5040);
    clr;
    wr(MISC_CTRL_OFS, 32'h0000_0270);
    run_mst(12'h07f, 32'h0000_3000, 1'b0);
    run_mst(12'h080, 32'h0000_4000, 1'b1);
    clr;
    wr(MISC_CTRL_OFS, 32'h0000_0070);
    run_mst(12'h12c, 32'h0000_5000, 1'b0);
  endtask
  task automatic t_parity;
    chk({20'h0, addr_par_out, data_par_out}, 32'h0000_02f2);
    wr(MISC_CTRL_OFS, 32'h0000_0071);
    chk({20'h0, addr_par_out, data_par_out}, 32'h0000_0d0d);
    psample(2'b11, 2'b00);
    wr(MISC_CTRL_OFS, 32'h0000_0073);
    psample(2'b01, 2'b01);
    clr;
    psample(2'b10, 2'b00);
    wr(MISC_CTRL_OFS, 32'h0000_0075);
    psample(2'b10, 2'b01);
    clr;
  endtask
  task automatic t_misc;
    logic [31:0] v [3] = '{32'h0000_0070, 32'h0000_00f0, 32'h0000_00d8};
    logic [2:0]  x [3] = '{3'b010, 3'b110, 3'b101};
    {mst_ext_req, slv_valid, slv_misaligned, prefetch_keep_enable} = 4'hf;
    for (int i = 0; i < 3; i++) begin
      wr(MISC_CTRL_OFS, v[i]);
      chk({29'h0, mst_ext_allow, misaligned_accept, prefetch_keep_active}, {29'h0, x[i]});
      chk({20'h0, misc_ctrl}, v[i]);
    end
    {mst_ext_req, slv_valid, slv_misaligned, prefetch_keep_enable} = 4'h0;
    tick;
  endtask
  task automatic t_retry;
    wr(MISC_CTRL_OFS, 32'h0000_0078);
    for (int i = 0; i < 4; i++) begin
      retry_chk(4'(1 << i), 1'b1);
    end
    retry_chk(4'h0, 1'b0);
    wr(MISC_CTRL_OFS, 32'h0000_0070);
    retry_chk(4'h8, 1'b0);
  endtask

  // verdict
  task automatic give_verdict;
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_log;
    t_limit;
    t_parity;
    t_misc;
    t_retry;
    give_verdict;
  end

  // watchdog
  initial begin
    #100000;
    num_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
